// file: pkg/qdc_pkg.sv
// Constants, types and payload layout of the quad converter command decoder
`default_nettype none
package qdc_pkg;
    // Widths
    localparam int CODE_W = 12;
    localparam int REG_W  = 14;
    localparam int NCH    = 4;
    // Fixed upper five bits of the 7-bit slave address
    localparam logic [4:0] ADDR_PREFIX = 5'h13;
    // Bits per byte before the acknowledge clock
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Command byte field positions
    localparam int CMD_MODE_HI = 5;
    localparam int CMD_MODE_LO = 4;
    localparam int CMD_BIT2    = 2;
    localparam int CMD_CH_HI   = 2;
    localparam int CMD_CH_LO   = 1;
    localparam int CMD_PD      = 0;
    // Power-down code position in the first data byte
    localparam int PDC_HI = 7;
    localparam int PDC_LO = 6;
    // Load modes
    localparam logic [1:0] MODE_HOLD  = 2'h0;
    localparam logic [1:0] MODE_ONE   = 2'h1;
    localparam logic [1:0] MODE_ALL   = 2'h2;
    localparam logic [1:0] MODE_BCAST = 2'h3;
    // Values after reset
    localparam logic [REG_W-1:0] REG_RST  = 14'h0000;
    localparam logic [7:0]       BYTE_RST = 8'h00;

    // Link receiver states, Gray coded along the write path
    typedef enum logic [2:0] {
        QDC_IDLE = 3'h0,
        QDC_ADDR = 3'h1,
        QDC_CMD  = 3'h3,
        QDC_MSB  = 3'h2,
        QDC_LSB  = 3'h6,
        QDC_DONE = 3'h7
    } qdc_state_t;

    // One decoded update passed from the link to the register domain
    typedef struct packed {
        logic [1:0]       mode;
        logic [1:0]       chan;
        logic             bit2;
        logic             pd;
        logic [REG_W-1:0] value;
    } qdc_upd_t;
endpackage
`default_nettype wire

// file: hdl/qdc_decoder.sv
// Two-wire write receiver, holding and output registers of a quad converter
// Summary of operation
// - First byte after the write address is the command: mode, channel, power-down flag.
// - Mode 00 writes only the selected holding register; outputs stay unchanged.
// - Mode 01 writes the selected holding register and copies it to its output.
// - Mode 10 writes the selected holding register, then loads all outputs from holding.
// - Mode 11 with bit 2 clear copies all holding registers to outputs.
// - Mode 11, bit 2 set, flag clear loads the data word into all outputs.
// - Mode 11, bit 2 set, flag set powers down all outputs with the code.
// - First data byte is the upper eight bits of the 12-bit value.
// - With the flag set, first data byte bits 7:6 give the power-down code.
// - Second data byte upper nibble is the low four bits; lower nibble ignored.
// - Updates happen at the falling clock edge ending the second byte's acknowledge.
// - All registers read back as zero after power-on reset.
// - Rising edge on the load input copies all holding registers to outputs.
// - Each channel has a 14-bit holding register: code on top, data below.
// - Each channel has a 14-bit output register; writing it updates the output.
// - The device answers its 7-bit address as a write target.
// - With the flag clear, byte pairs repeat until stop or repeated start.
// - With the flag set, exactly two data bytes are accepted after the command.
`default_nettype none
module qdc_decoder
    import qdc_pkg::*;
(
    // System clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_n,
    // Link oversampling clock
    input  wire logic                      i_link_clk,
    // Two-wire bus pins
    input  wire logic                      i_scl,
    input  wire logic                      i_sda,
    output logic                           o_sda,
    output logic                           o_sda_oe,
    // Address straps
    input  wire logic                      i_addr_pin_hi,
    input  wire logic                      i_addr_pin_lo,
    // Asynchronous load trigger
    input  wire logic                      i_async_load_trigger,
    // Register contents per channel
    output logic [NCH-1:0][REG_W-1:0]      o_holding_register,
    output logic [NCH-1:0][REG_W-1:0]      o_channel_output
);

    // Builds the 14-bit register word from the two data bytes
    function automatic logic [REG_W-1:0] build_value(input logic       pd,
                                                     input logic [7:0] msb,
                                                     input logic [7:0] lsb);
        logic [REG_W-1:0] v;
        if (pd) begin
            v = {msb[PDC_HI:PDC_LO], 12'h000};
        end else begin
            v = {2'h0, msb, lsb[7:4]};
        end
        return v;
    endfunction

    // ---------------- Reset release in both domains ----------------
    logic sys_rst_s1_r;
    logic sys_rst_r;
    logic lnk_rst_s1_r;
    logic lnk_rst_r;

    // Reset synchroniser, system domain
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_rst_s1_r <= 1'b0;
            sys_rst_r    <= 1'b0;
        end else begin
            sys_rst_s1_r <= 1'b1;
            sys_rst_r    <= sys_rst_s1_r;
        end
    end

    // Reset synchroniser, link domain
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lnk_rst_s1_r <= 1'b0;
            lnk_rst_r    <= 1'b0;
        end else begin
            lnk_rst_s1_r <= 1'b1;
            lnk_rst_r    <= lnk_rst_s1_r;
        end
    end

    // ---------------- Link domain: pin synchronisers ----------------
    logic       scl_s1_r, scl_s2_r, scl_s3_r;
    logic       sda_s1_r, sda_s2_r, sda_s3_r;
    logic [1:0] apin_s1_r, apin_s2_r;

    // Two flops per pin, a third stage on clock and data for edge detection
    always_ff @(posedge i_link_clk or negedge lnk_rst_r) begin
        if (!lnk_rst_r) begin
            scl_s1_r  <= 1'b1;
            scl_s2_r  <= 1'b1;
            scl_s3_r  <= 1'b1;
            sda_s1_r  <= 1'b1;
            sda_s2_r  <= 1'b1;
            sda_s3_r  <= 1'b1;
            apin_s1_r <= 2'h0;
            apin_s2_r <= 2'h0;
        end else begin
            scl_s1_r  <= i_scl;
            scl_s2_r  <= scl_s1_r;
            scl_s3_r  <= scl_s2_r;
            sda_s1_r  <= i_sda;
            sda_s2_r  <= sda_s1_r;
            sda_s3_r  <= sda_s2_r;
            apin_s1_r <= {i_addr_pin_hi, i_addr_pin_lo};
            apin_s2_r <= apin_s1_r;
        end
    end

    // Bus events
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s2_r & ~scl_s3_r;
    assign scl_fall  = ~scl_s2_r & scl_s3_r;
    assign bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
    assign bus_stop  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

    // ---------------- Link domain: byte receiver ----------------
    qdc_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shreg_r, shreg_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] msb_r, msb_nxt;
    logic       in_ack_r, in_ack_nxt;
    logic       pend_r, pend_nxt;
    logic       sda_oe_r, sda_oe_nxt;
    logic       req_r, req_nxt;
    qdc_upd_t   upd_r, upd_nxt;

    // Next state of the receiver
    always_comb begin
        state_nxt   = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shreg_nxt   = shreg_r;
        cmd_nxt     = cmd_r;
        msb_nxt     = msb_r;
        in_ack_nxt  = in_ack_r;
        pend_nxt    = pend_r;
        sda_oe_nxt  = sda_oe_r;
        req_nxt     = req_r;
        upd_nxt     = upd_r;
        if (bus_start) begin
            // Start or repeated start ends any sequence
            state_nxt   = QDC_ADDR;
            bit_cnt_nxt = 4'h0;
            in_ack_nxt  = 1'b0;
            pend_nxt    = 1'b0;
            sda_oe_nxt  = 1'b0;
        end else if (bus_stop) begin
            state_nxt   = QDC_IDLE;
            bit_cnt_nxt = 4'h0;
            in_ack_nxt  = 1'b0;
            pend_nxt    = 1'b0;
            sda_oe_nxt  = 1'b0;
        end else if (state_r != QDC_IDLE) begin
            if (scl_rise && !in_ack_r && bit_cnt_r < BITS_PER_BYTE) begin
                shreg_nxt   = {shreg_r[6:0], sda_s2_r};
                bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
            if (scl_fall && in_ack_r) begin
                // End of the acknowledge clock
                in_ack_nxt  = 1'b0;
                sda_oe_nxt  = 1'b0;
                bit_cnt_nxt = 4'h0;
                if (pend_r) begin
                    req_nxt  = ~req_r;
                    pend_nxt = 1'b0;
                end
            end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
                in_ack_nxt = 1'b1;
                case (state_r)
                    QDC_ADDR: begin
                        if (shreg_r[7:3] == ADDR_PREFIX && shreg_r[2:1] == apin_s2_r
                            && !shreg_r[0]) begin
                            sda_oe_nxt = 1'b1;
                            state_nxt  = QDC_CMD;
                        end else begin
                            state_nxt  = QDC_IDLE;
                            in_ack_nxt = 1'b0;
                        end
                    end
                    QDC_CMD: begin
                        cmd_nxt    = shreg_r;
                        sda_oe_nxt = 1'b1;
                        state_nxt  = QDC_MSB;
                    end
                    QDC_MSB: begin
                        msb_nxt    = shreg_r;
                        sda_oe_nxt = 1'b1;
                        state_nxt  = QDC_LSB;
                    end
                    QDC_LSB: begin
                        upd_nxt.mode  = cmd_r[CMD_MODE_HI:CMD_MODE_LO];
                        upd_nxt.chan  = cmd_r[CMD_CH_HI:CMD_CH_LO];
                        upd_nxt.bit2  = cmd_r[CMD_BIT2];
                        upd_nxt.pd    = cmd_r[CMD_PD];
                        upd_nxt.value = build_value(cmd_r[CMD_PD], msb_r, shreg_r);
                        pend_nxt      = 1'b1;
                        sda_oe_nxt    = 1'b1;
                        // Data pairs repeat; power-down takes one pair only
                        state_nxt = cmd_r[CMD_PD] ? QDC_DONE : QDC_MSB;
                    end
                    default: begin
                        sda_oe_nxt = 1'b0;
                    end
                endcase
            end
        end
    end

    // Receiver registers
    always_ff @(posedge i_link_clk or negedge lnk_rst_r) begin
        if (!lnk_rst_r) begin
            state_r   <= QDC_IDLE;
            bit_cnt_r <= 4'h0;
            shreg_r   <= BYTE_RST;
            cmd_r     <= BYTE_RST;
            msb_r     <= BYTE_RST;
            in_ack_r  <= 1'b0;
            pend_r    <= 1'b0;
            sda_oe_r  <= 1'b0;
            req_r     <= 1'b0;
            upd_r     <= '0;
        end else begin
            state_r   <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shreg_r   <= shreg_nxt;
            cmd_r     <= cmd_nxt;
            msb_r     <= msb_nxt;
            in_ack_r  <= in_ack_nxt;
            pend_r    <= pend_nxt;
            sda_oe_r  <= sda_oe_nxt;
            req_r     <= req_nxt;
            upd_r     <= upd_nxt;
        end
    end

    // Open-drain data pin: only ever pulls low
    assign o_sda    = 1'b0;
    assign o_sda_oe = sda_oe_r;

    // ---------------- System domain: crossing and load input ----------------
    logic req_s1_r, req_s2_r, req_s3_r;
    logic ld_s1_r, ld_s2_r, ld_s3_r;

    // Toggle request and load pin, two flops each plus an edge stage
    always_ff @(posedge i_sys_clk or negedge sys_rst_r) begin
        if (!sys_rst_r) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            ld_s1_r  <= 1'b0;
            ld_s2_r  <= 1'b0;
            ld_s3_r  <= 1'b0;
        end else begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            ld_s1_r  <= i_async_load_trigger;
            ld_s2_r  <= ld_s1_r;
            ld_s3_r  <= ld_s2_r;
        end
    end

    // Payload is stable for many link clocks after each toggle
    logic fire, ld_rise;
    assign fire    = req_s2_r ^ req_s3_r;
    assign ld_rise = ld_s2_r & ~ld_s3_r;

    // ---------------- System domain: holding and output registers ----------------
    logic [NCH-1:0][REG_W-1:0] hold_r, hold_nxt;
    logic [NCH-1:0][REG_W-1:0] out_r, out_nxt;

    // Apply the decoded command, then the load pin
    always_comb begin
        hold_nxt = hold_r;
        out_nxt  = out_r;
        if (fire) begin
            case (upd_r.mode)
                MODE_HOLD: begin
                    hold_nxt[upd_r.chan] = upd_r.value;
                end
                MODE_ONE: begin
                    hold_nxt[upd_r.chan] = upd_r.value;
                    out_nxt[upd_r.chan]  = upd_r.value;
                end
                MODE_ALL: begin
                    hold_nxt[upd_r.chan] = upd_r.value;
                    out_nxt              = hold_nxt;
                end
                default: begin
                    if (!upd_r.bit2) begin
                        out_nxt = hold_r;
                    end else begin
                        out_nxt = {NCH{upd_r.value}};
                    end
                end
            endcase
        end
        if (ld_rise) begin
            out_nxt = hold_nxt;
        end
    end

    // Register file, zero after reset
    always_ff @(posedge i_sys_clk or negedge sys_rst_r) begin
        if (!sys_rst_r) begin
            hold_r <= {NCH{REG_RST}};
            out_r  <= {NCH{REG_RST}};
        end else begin
            hold_r <= hold_nxt;
            out_r  <= out_nxt;
        end
    end

    assign o_holding_register = hold_r;
    assign o_channel_output   = out_r;

    // ---------------- Assertions, system domain ----------------
    AST_MODE00_HOLD: assert property (@(posedge i_sys_clk) disable iff (!sys_rst_r)
        fire && upd_r.mode == MODE_HOLD && !ld_rise
        |=> hold_r[$past(upd_r.chan)] == $past(upd_r.value) && out_r == $past(out_r))
        else $error("mode 00 did not write holding only");

    AST_MODE01_ONE: assert property (@(posedge i_sys_clk) disable iff (!sys_rst_r)
        fire && upd_r.mode == MODE_ONE && !ld_rise
        |=> out_r[$past(upd_r.chan)] == $past(upd_r.value))
        else $error("mode 01 did not load the selected output");

    AST_MODE10_ALL: assert property (@(posedge i_sys_clk) disable iff (!sys_rst_r)
        fire && upd_r.mode == MODE_ALL
        |=> out_r == hold_r && hold_r[$past(upd_r.chan)] == $past(upd_r.value))
        else $error("mode 10 did not load all outputs");

    AST_BCAST_COPY: assert property (@(posedge i_sys_clk) disable iff (!sys_rst_r)
        fire && upd_r.mode == MODE_BCAST && !upd_r.bit2 && !ld_rise
        |=> out_r == $past(hold_r) && hold_r == $past(hold_r))
        else $error("broadcast copy wrong");

    AST_BCAST_DATA: assert property (@(posedge i_sys_clk) disable iff (!sys_rst_r)
        fire && upd_r.mode == MODE_BCAST && upd_r.bit2 && !ld_rise
        |=> out_r == {NCH{$past(upd_r.value)}} && hold_r == $past(hold_r))
        else $error("broadcast data not in all outputs");

    AST_LOAD_PIN: assert property (@(posedge i_sys_clk) disable iff (!sys_rst_r)
        $rose(ld_s2_r) |=> out_r == hold_r)
        else $error("load pin edge did not copy holding registers");

    AST_QUIET_OUT: assert property (@(posedge i_sys_clk) disable iff (!sys_rst_r)
        !fire && !ld_rise |=> $stable(out_r))
        else $error("output changed without a cause");

    // ---------------- Assertions, link domain ----------------
    AST_ACK_ONLY: assert property (@(posedge i_link_clk) disable iff (!lnk_rst_r)
        $rose(sda_oe_r) |-> in_ack_r && $past(bit_cnt_r) == BITS_PER_BYTE)
        else $error("data pin pulled low outside an acknowledge");

    AST_PD_PAIR: assert property (@(posedge i_link_clk) disable iff (!lnk_rst_r)
        state_r == QDC_LSB && scl_fall && !in_ack_r && bit_cnt_r == BITS_PER_BYTE
        && cmd_r[CMD_PD] && !bus_start && !bus_stop |=> state_r == QDC_DONE)
        else $error("power-down sequence accepted more than two bytes");

    AST_PD_FORMAT: assert property (@(posedge i_link_clk) disable iff (!lnk_rst_r)
        $changed(upd_r) && upd_r.pd |-> upd_r.value[CODE_W-1:0] == 12'h000)
        else $error("power-down word carries data bits");

endmodule
`default_nettype wire

// file: verif/qdc_bus_master.sv
// Two-wire bus master model that writes command and data bytes to the decoder
`default_nettype none
module qdc_bus_master (
    // Data line as seen on the wire
    input  wire logic i_sda,
    // Clock level and open-drain data pull, high pulls the line low
    output logic      o_scl,
    output logic      o_sda_low
);
    timeunit 1ns;
    timeprecision 100ps;

    // Half period of the bus clock; raise it to model a slow master
    int half = 200;

    // Idle bus: both lines released to their pull-ups
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        #(half / 4) o_sda_low = 1'b0;
        #(half) o_scl = 1'b1;
        #(half) o_sda_low = 1'b1;
        #(half) o_scl = 1'b0;
    endtask

    // Stop: data rises while the clock is high, then the bus rests
    task automatic stop();
        #(half / 4) o_sda_low = 1'b1;
        #(half) o_scl = 1'b1;
        #(half) o_sda_low = 1'b0;
        #(half);
    endtask

    // One byte, most significant bit first, data moved a quarter after the fall
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(half / 4) o_sda_low = ~b[i];
            #(half - half / 4) o_scl = 1'b1;
            #(half) o_scl = 1'b0;
        end
        // Release data so the receiver can acknowledge
        #(half / 4) o_sda_low = 1'b0;
        #(half - half / 4) o_scl = 1'b1;
        ack = ~i_sda;
        #(half) o_scl = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verif/qdc_decoder_tb.sv
// Self-checking bench for the quad converter command decoder
`default_nettype none
module qdc_decoder_tb
    import qdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // Bus address with the straps tied to 1 and 0
    localparam logic [6:0] ADDR7 = {ADDR_PREFIX, 2'h2};

    logic                      sys_clk   = 1'b0;
    logic                      link_clk  = 1'b0;
    logic                      rst_n     = 1'b0;
    logic                      load_trig = 1'b0;
    logic                      m_scl;
    logic                      m_sda_low;
    logic                      dut_sda;
    logic                      dut_sda_oe;
    logic                      sda_w;
    logic [NCH-1:0][REG_W-1:0] hold;
    logic [NCH-1:0][REG_W-1:0] outr;
    logic [NCH-1:0][REG_W-1:0] eh;
    logic [NCH-1:0][REG_W-1:0] eo;
    logic [11:0]               dv [NCH] = '{12'h0ff, 12'h800, 12'h5a3, 12'hfff};
    logic [1:0]                md [NCH] = '{MODE_HOLD, MODE_ONE, MODE_ALL, MODE_ONE};
    int                        errors   = 0;
    int                        n_tests  = 0;
    int                        cycles   = 0;

    // Clocks: system 50 ns, link 6 ns with an unrelated phase
    always #25 sys_clk = ~sys_clk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    // Data wire with pull-up: low when either party pulls it
    assign sda_w = ~(m_sda_low | (dut_sda_oe & ~dut_sda));

    // Design under test
    qdc_decoder DUT (
        .i_sys_clk            (sys_clk),
        .i_rst_n              (rst_n),
        .i_link_clk           (link_clk),
        .i_scl                (m_scl),
        .i_sda                (sda_w),
        .o_sda                (dut_sda),
        .o_sda_oe             (dut_sda_oe),
        .i_addr_pin_hi        (1'b1),
        .i_addr_pin_lo        (1'b0),
        .i_async_load_trigger (load_trig),
        .o_holding_register   (hold),
        .o_channel_output     (outr)
    );

    // Bus master on the far side
    qdc_bus_master m (
        .i_sda     (sda_w),
        .o_scl     (m_scl),
        .o_sda_low (m_sda_low)
    );

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard: tests need about 6500 system cycles, ceiling near twice that
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 12000) begin
            errors++;
            close_out();
        end
    end

    // One comparison with report
    task automatic check(input string what, input logic [REG_W-1:0] exp,
                         input logic [REG_W-1:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            errors++;
        end
    endtask

    // Compare every holding and output register with the expectation
    task automatic chk_all(input string what);
        for (int c = 0; c < NCH; c++) begin
            check({what, " holding"}, eh[c], hold[c]);
            check({what, " output"}, eo[c], outr[c]);
        end
    endtask

    // One byte on the bus with the expected acknowledge
    task automatic bus_byte(input logic [7:0] b, input logic exp_ack);
        logic ack;
        m.put_byte(b, ack);
        check("acknowledge", {13'h0, exp_ack}, {13'h0, ack});
    endtask

    // Data pair; nothing may change before the acknowledge clock falls
    task automatic pair(input logic [15:0] w);
        bus_byte(w[15:8], 1'b1);
        bus_byte(w[7:0], 1'b1);
        chk_all("before update");
        repeat (10) @(posedge sys_clk);
        #1;
    endtask

    // Whole write: address, command, one pair, optional refused byte
    task automatic wr(input logic [7:0] cmd, input logic [15:0] w, input logic extra);
        m.start();
        bus_byte({ADDR7, 1'b0}, 1'b1);
        bus_byte(cmd, 1'b1);
        pair(w);
        if (extra) begin
            bus_byte(8'h00, 1'b0);
        end
        m.stop();
    endtask

    // Command byte from mode, channel and power-down flag
    function automatic logic [7:0] cmd_of(logic [1:0] mode, logic [1:0] ch, logic pd);
        return {2'h0, mode, 1'b0, ch, pd};
    endfunction

    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        eh = '0;
        eo = '0;
        chk_all("reset");
        $display("test 1 done");
        for (int c = 0; c < NCH; c++) begin
            wr(cmd_of(MODE_HOLD, 2'(c), 1'b0), {dv[c], 4'hb}, 1'b0);
            eh[c] = {2'h0, dv[c]};
            chk_all("hold only");
        end
        $display("test 2 done");
        wr(8'h1c, {12'h123, 4'h5}, 1'b0);
        eh[2] = 14'h0123;
        eo[2] = 14'h0123;
        chk_all("single load");
        wr(cmd_of(MODE_ALL, 2'h1, 1'b0), {12'hace, 4'h0}, 1'b0);
        eh[1] = 14'h0ace;
        eo = eh;
        chk_all("load all");
        $display("test 3 done");
        wr(cmd_of(MODE_HOLD, 2'h3, 1'b0), {12'h456, 4'hf}, 1'b0);
        eh[3] = 14'h0456;
        wr(8'hfb, 16'hffff, 1'b0);
        eo = eh;
        chk_all("broadcast copy");
        wr(8'h34, {12'h7e1, 4'h3}, 1'b0);
        eo = {NCH{14'h07e1}};
        chk_all("broadcast data");
        wr(8'h35, 16'h8000, 1'b1);
        eo = {NCH{14'h2000}};
        chk_all("broadcast power-down");
        $display("test 4 done");
        for (int k = 0; k < NCH; k++) begin
            wr(cmd_of(md[k], 2'(k), 1'b1), {2'(k), 14'h0}, 1'b0);
            eh[k] = {2'(k), 12'h000};
            if (md[k] == MODE_ONE) begin
                eo[k] = eh[k];
            end
            if (md[k] == MODE_ALL) begin
                eo = eh;
            end
            chk_all("channel power-down");
        end
        $display("test 5 done");
        // Slow master, two pairs after one command
        m.half = 500;
        m.start();
        bus_byte({ADDR7, 1'b0}, 1'b1);
        bus_byte(cmd_of(MODE_ONE, 2'h0, 1'b0), 1'b1);
        pair({12'h001, 4'h0});
        eh[0] = 14'h0001;
        eo[0] = 14'h0001;
        chk_all("first pair");
        pair({12'hfff, 4'hf});
        m.stop();
        eh[0] = 14'h0fff;
        eo[0] = 14'h0fff;
        chk_all("second pair");
        m.half = 200;
        $display("test 6 done");
        // Another device's address and a read request are both ignored
        m.start();
        bus_byte({ADDR_PREFIX, 2'h1, 1'b0}, 1'b0);
        m.stop();
        m.start();
        bus_byte({ADDR7, 1'b1}, 1'b0);
        m.stop();
        chk_all("refused");
        $display("test 7 done");
        // Load input copies holding to outputs after a holding write
        wr(cmd_of(MODE_HOLD, 2'h2, 1'b0), {12'hbee, 4'h0}, 1'b0);
        eh[2] = 14'h0bee;
        chk_all("before load");
        @(posedge sys_clk) #1 load_trig = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1 load_trig = 1'b0;
        eo = eh;
        chk_all("load input");
        $display("test 8 done");
        close_out();
    end
endmodule
`default_nettype wire
